// ---- rtl/twt_regs.svh ----
/*
 * Register offsets, field positions, reset values and fixed counts of the
 * two-wire controller. Assumes a 16-bit register port with 8-bit offsets.
 */
`ifndef TWT_REGS_SVH
`define TWT_REGS_SVH

// Register offsets
`define TWT_OFS_CTRL      8'h00
`define TWT_OFS_STATUS    8'h01
`define TWT_OFS_IRQ_EN    8'h03
`define TWT_OFS_SCL_PER   8'h08
`define TWT_OFS_TMO       8'h09
`define TWT_OFS_OWN_ADDR  8'h0a

// Control register fields
`define TWT_CTL_ENABLE    0
`define TWT_CTL_MASTER    1
`define TWT_CTL_START     2
`define TWT_CTL_ACK       3

// Status and interrupt enable fields
`define TWT_ST_TIMEOUT    4
`define TWT_ST_MATCH      5
`define TWT_ST_SCL        10
`define TWT_ST_STOP       11
`define TWT_ST_ACTIVE     14
`define TWT_ST_BUSBUSY    15
`define TWT_IE_MASK       16'h0830

// Reset values
`define TWT_RST_SCL_PER   16'h0204
`define TWT_RST_CTRL      16'h0000

// Least effective low and high counts in master mode
`define TWT_MIN_LOW       8'h04
`define TWT_MIN_HIGH      8'h02

`endif

// ---- rtl/twt_pkg.sv ----
/*
 * Types shared by the two-wire controller.
 * Assumes the offsets and fields of twt_regs.svh.
 */
package twt_pkg;

	// Master sequencer, Gray coded from idle through start, low, wait and high to stop
	typedef enum logic [2:0] {
		TWT_M_IDLE  = 3'h0,
		TWT_M_START = 3'h1,
		TWT_M_LOW   = 3'h3,
		TWT_M_WAITH = 3'h2,
		TWT_M_HIGH  = 3'h6,
		TWT_M_STOP  = 3'h7
	} twt_mst_e;

	// One register port request
	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} twt_bus_s;

endpackage

// ---- rtl/twt_ctrl.sv ----
/*
 * Two-wire controller: register port, SCL period generation, master
 * timeout, START/STOP detection, own-address match with auto acknowledge.
 * Assumes SCL and SDA are open-drain wires resolved outside from the
 * enables, and a register master that holds strobes one cycle.
 */
`timescale 1ns/100ps
`include "twt_regs.svh"

module twt_ctrl (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             srst_in,
	// Register port
	input  wire twt_pkg::twt_bus_s bus_in,
	output logic [15:0]           rd_data_out,
	// Interrupt
	output logic                  irq_out,
	// Bus pins
	input  wire logic             scl_in,
	output logic                  scl_level_out,
	output logic                  scl_oe_out,
	input  wire logic             sda_in,
	output logic                  sda_level_out,
	output logic                  sda_oe_out
);

	// Registers seen by software
	logic [15:0]       ctrl_ff;       // Enable, master, start, ack, tx byte
	logic [15:0]       ie_ff;         // Interrupt enables
	logic [15:0]       per_ff;        // SCL high and low counts
	logic [7:0]        tmo_ff;        // Timeout in bit periods
	logic [15:0]       own_ff;        // Own target address
	logic              fl_tmo_ff;     // Sticky timeout flag
	logic              fl_match_ff;   // Sticky address match flag
	logic              fl_stop_ff;    // Sticky STOP flag
	logic              active_ff;     // Controller active
	logic              busy_ff;       // Bus between START and STOP
	logic [15:0]       rd_data_ff;    // Read answer
	logic              irq_ff;        // Interrupt level
	// Pin sampling
	logic [2:0]        scl_sy_ff;     // SCL synchroniser
	logic [2:0]        sda_sy_ff;     // SDA synchroniser
	logic              scl_ff;        // Filtered SCL
	logic              sda_ff;        // Filtered SDA
	logic              scl_d_ff;      // SCL one cycle back
	logic              sda_d_ff;      // SDA one cycle back
	// Master sequencer
	twt_pkg::twt_mst_e mst_ff;        // Sequencer state
	logic [7:0]        ph_cnt_ff;     // Phase cycle count
	logic [3:0]        bit_ff;        // Bit number in frame
	logic [7:0]        tx_sh_ff;      // Outgoing byte
	logic              stopping_ff;   // Final phase toward STOP
	logic              m_scl_ff;      // Master pulls SCL
	logic              m_sda_ff;      // Master pulls SDA
	logic [18:0]       tmo_cnt_ff;    // Timeout cycle count
	// Target receiver
	logic              sl_act_ff;     // Address phase in progress
	logic [3:0]        sl_bits_ff;    // Address bits received
	logic [7:0]        sl_sh_ff;      // Received address byte
	logic              sl_drv_ff;     // Target pulls SDA for ack
	logic              scl_oe_ff;     // Pin enable registers
	logic              sda_oe_ff;

	// Combinational terms
	logic [7:0]        low_eff;       // Effective low count
	logic [7:0]        high_eff;      // Effective high count
	logic [9:0]        bit_per;       // Cycles per bit period
	logic [18:0]       tmo_lim;       // Timeout in cycles
	logic              scl_rise;
	logic              scl_fall;
	logic              start_det;
	logic              stop_det;
	logic              start_go;      // Start request taken
	logic              start_fail;    // START cannot be made
	logic              tmo_hit;       // Timeout reached
	logic              addr_hit;      // Own address matched
	logic              rd_clr;        // Status read clears flags
	logic              en;
	logic              msel;

	assign en       = ctrl_ff[`TWT_CTL_ENABLE];
	assign msel     = ctrl_ff[`TWT_CTL_MASTER];
	// Enforce least counts in master mode
	assign low_eff  = (per_ff[7:0] < `TWT_MIN_LOW) ? `TWT_MIN_LOW : per_ff[7:0];
	assign high_eff = (per_ff[15:8] < `TWT_MIN_HIGH) ? `TWT_MIN_HIGH : per_ff[15:8];
	assign bit_per  = {2'h0, low_eff} + {2'h0, high_eff} + 10'h002;
	assign tmo_lim  = {10'h000, {1'b0, tmo_ff} + 9'h001} * {9'h000, bit_per};
	assign scl_rise  = scl_ff & ~scl_d_ff;
	assign scl_fall  = ~scl_ff & scl_d_ff;
	assign start_det = scl_ff & scl_d_ff & ~sda_ff & sda_d_ff;
	assign stop_det  = scl_ff & scl_d_ff & sda_ff & ~sda_d_ff;
	assign start_go  = ctrl_ff[`TWT_CTL_START] & msel & en & (mst_ff == twt_pkg::TWT_M_IDLE);
	assign start_fail = start_go & (busy_ff | ~scl_ff | ~sda_ff);
	// Only a master waiting for SCL high with a nonzero limit times out
	assign tmo_hit  = (mst_ff == twt_pkg::TWT_M_WAITH) & msel & (tmo_ff != 8'h00)
		& (tmo_cnt_ff >= tmo_lim);
	assign addr_hit = scl_fall & sl_act_ff & (sl_bits_ff == 4'h8)
		& (sl_sh_ff[7:1] == own_ff[6:0]);
	assign rd_clr   = bus_in.rd & (bus_in.addr == `TWT_OFS_STATUS);

	// Pin synchronisers: a change counts when stages two and three agree
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			scl_sy_ff <= 3'h7;
			sda_sy_ff <= 3'h7;
			scl_ff    <= 1'b1;
			sda_ff    <= 1'b1;
			scl_d_ff  <= 1'b1;
			sda_d_ff  <= 1'b1;
		end else begin
			scl_sy_ff <= {scl_sy_ff[1:0], scl_in};
			sda_sy_ff <= {sda_sy_ff[1:0], sda_in};
			if (scl_sy_ff[1] == scl_sy_ff[2]) begin
				scl_ff <= scl_sy_ff[2];
			end
			if (sda_sy_ff[1] == sda_sy_ff[2]) begin
				sda_ff <= sda_sy_ff[2];
			end
			scl_d_ff <= scl_ff;
			sda_d_ff <= sda_ff;
		end
	end

	// Control register; hardware updates win over software
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			ctrl_ff <= `TWT_RST_CTRL;
		end else begin
			if (bus_in.wr && bus_in.addr == `TWT_OFS_CTRL) begin
				ctrl_ff <= bus_in.wdata;
			end
			if (start_go) begin
				ctrl_ff[`TWT_CTL_START] <= 1'b0;
			end
			if (addr_hit) begin
				ctrl_ff[`TWT_CTL_MASTER] <= 1'b0;
			end
		end
	end

	// Configuration registers
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			ie_ff  <= 16'h0000;
			per_ff <= `TWT_RST_SCL_PER;
			tmo_ff <= 8'h00;
			own_ff <= 16'h0000;
		end else if (bus_in.wr) begin
			case (bus_in.addr)
				`TWT_OFS_IRQ_EN: begin
					ie_ff <= bus_in.wdata & `TWT_IE_MASK;
				end
				`TWT_OFS_SCL_PER: begin
					if (!active_ff) begin
						per_ff <= bus_in.wdata;
					end
				end
				`TWT_OFS_TMO: begin
					tmo_ff <= bus_in.wdata[7:0];
				end
				`TWT_OFS_OWN_ADDR: begin
					own_ff <= {6'h00, bus_in.wdata[9:0]};
				end
				default: begin
				end
			endcase
		end
	end

	// Sticky flags: a status read clears, a new event in the same cycle wins
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			fl_tmo_ff   <= 1'b0;
			fl_match_ff <= 1'b0;
			fl_stop_ff  <= 1'b0;
		end else begin
			fl_tmo_ff   <= tmo_hit | start_fail | (fl_tmo_ff & ~rd_clr);
			fl_match_ff <= addr_hit | (fl_match_ff & ~rd_clr);
			fl_stop_ff  <= stop_det | (fl_stop_ff & ~rd_clr);
		end
	end

	// Bus busy and controller active indications
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			busy_ff   <= 1'b0;
			active_ff <= 1'b0;
		end else begin
			busy_ff   <= en & (start_det | (busy_ff & ~stop_det));
			active_ff <= (mst_ff != twt_pkg::TWT_M_IDLE) | sl_act_ff | busy_ff;
		end
	end

	// Read answer one cycle after the strobe; interrupt level
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rd_data_ff <= 16'h0000;
			irq_ff     <= 1'b0;
		end else begin
			rd_data_ff <= 16'h0000;
			if (bus_in.rd) begin
				case (bus_in.addr)
					`TWT_OFS_CTRL:     rd_data_ff <= ctrl_ff;
					`TWT_OFS_STATUS: begin
						rd_data_ff[`TWT_ST_TIMEOUT] <= fl_tmo_ff;
						rd_data_ff[`TWT_ST_MATCH]   <= fl_match_ff;
						rd_data_ff[`TWT_ST_SCL]     <= scl_ff;
						rd_data_ff[`TWT_ST_STOP]    <= fl_stop_ff;
						rd_data_ff[`TWT_ST_ACTIVE]  <= active_ff;
						rd_data_ff[`TWT_ST_BUSBUSY] <= busy_ff;
					end
					`TWT_OFS_IRQ_EN:   rd_data_ff <= ie_ff;
					`TWT_OFS_SCL_PER:  rd_data_ff <= per_ff;
					`TWT_OFS_TMO:      rd_data_ff <= {8'h00, tmo_ff};
					`TWT_OFS_OWN_ADDR: rd_data_ff <= own_ff;
					default:           rd_data_ff <= 16'h0000;
				endcase
			end
			irq_ff <= (fl_stop_ff & ie_ff[`TWT_ST_STOP])
				| (fl_match_ff & ie_ff[`TWT_ST_MATCH])
				| (fl_tmo_ff & ie_ff[`TWT_ST_TIMEOUT]);
		end
	end

	// Master sequencer: START, eight data bits, ack bit, STOP
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			mst_ff      <= twt_pkg::TWT_M_IDLE;
			ph_cnt_ff   <= 8'h00;
			bit_ff      <= 4'h0;
			tx_sh_ff    <= 8'h00;
			stopping_ff <= 1'b0;
			m_scl_ff    <= 1'b0;
			m_sda_ff    <= 1'b0;
		end else if (!msel || !en || tmo_hit) begin
			// Slave mode or timeout: release both lines
			mst_ff   <= twt_pkg::TWT_M_IDLE;
			m_scl_ff <= 1'b0;
			m_sda_ff <= 1'b0;
		end else begin
			case (mst_ff)
				twt_pkg::TWT_M_IDLE: begin
					if (start_go && !start_fail) begin
						mst_ff      <= twt_pkg::TWT_M_START;
						m_sda_ff    <= 1'b1;
						ph_cnt_ff   <= 8'h00;
						bit_ff      <= 4'h0;
						stopping_ff <= 1'b0;
						tx_sh_ff    <= ctrl_ff[15:8];
					end
				end
				twt_pkg::TWT_M_START: begin
					ph_cnt_ff <= ph_cnt_ff + 8'h01;
					if (ph_cnt_ff >= high_eff) begin
						mst_ff    <= twt_pkg::TWT_M_LOW;
						m_scl_ff  <= 1'b1;
						ph_cnt_ff <= 8'h00;
					end
				end
				twt_pkg::TWT_M_LOW: begin
					// Data changes one cycle after SCL is pulled low
					ph_cnt_ff <= ph_cnt_ff + 8'h01;
					if (stopping_ff) begin
						m_sda_ff <= 1'b1;
					end else begin
						m_sda_ff <= (bit_ff < 4'h8) ? ~tx_sh_ff[7] : 1'b0;
					end
					if (ph_cnt_ff >= low_eff) begin
						mst_ff    <= twt_pkg::TWT_M_WAITH;
						m_scl_ff  <= 1'b0;
						ph_cnt_ff <= 8'h00;
					end
				end
				twt_pkg::TWT_M_WAITH: begin
					// A stretching party holds SCL low; wait for it
					if (scl_ff) begin
						mst_ff <= twt_pkg::TWT_M_HIGH;
					end
				end
				twt_pkg::TWT_M_HIGH: begin
					ph_cnt_ff <= ph_cnt_ff + 8'h01;
					if (ph_cnt_ff >= high_eff) begin
						ph_cnt_ff <= 8'h00;
						if (stopping_ff) begin
							mst_ff   <= twt_pkg::TWT_M_STOP;
							m_sda_ff <= 1'b0;
						end else begin
							mst_ff   <= twt_pkg::TWT_M_LOW;
							m_scl_ff <= 1'b1;
							tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
							if (bit_ff == 4'h8) begin
								stopping_ff <= 1'b1;
							end else begin
								bit_ff <= bit_ff + 4'h1;
							end
						end
					end
				end
				twt_pkg::TWT_M_STOP: begin
					// Bus free time after STOP
					ph_cnt_ff <= ph_cnt_ff + 8'h01;
					if (ph_cnt_ff >= high_eff) begin
						mst_ff <= twt_pkg::TWT_M_IDLE;
					end
				end
				default: begin
					mst_ff <= twt_pkg::TWT_M_IDLE;
				end
			endcase
		end
	end

	// Timeout counter in system clocks
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			tmo_cnt_ff <= 19'h00000;
		end else if (start_go || scl_fall) begin
			tmo_cnt_ff <= 19'h00000;
		end else if (mst_ff != twt_pkg::TWT_M_IDLE && tmo_cnt_ff != 19'h7ffff) begin
			tmo_cnt_ff <= tmo_cnt_ff + 19'h00001;
		end
	end

	// Target address receiver with automatic acknowledge
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			sl_act_ff  <= 1'b0;
			sl_bits_ff <= 4'h0;
			sl_sh_ff   <= 8'h00;
			sl_drv_ff  <= 1'b0;
		end else if (!en || stop_det) begin
			sl_act_ff <= 1'b0;
			sl_drv_ff <= 1'b0;
		end else if (start_det) begin
			sl_act_ff  <= (mst_ff == twt_pkg::TWT_M_IDLE);
			sl_bits_ff <= 4'h0;
			sl_drv_ff  <= 1'b0;
		end else if (sl_act_ff) begin
			if (scl_rise && sl_bits_ff < 4'h8) begin
				sl_sh_ff   <= {sl_sh_ff[6:0], sda_ff};
				sl_bits_ff <= sl_bits_ff + 4'h1;
			end else if (scl_fall && sl_bits_ff == 4'h8) begin
				sl_bits_ff <= 4'h9;
				sl_drv_ff  <= addr_hit & ~ctrl_ff[`TWT_CTL_ACK];
				sl_act_ff  <= addr_hit;
			end else if (scl_fall && sl_bits_ff == 4'h9) begin
				sl_drv_ff <= 1'b0;
				sl_act_ff <= 1'b0;
			end
		end
	end

	// Pin drivers: open drain, level always low
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			scl_oe_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
		end else begin
			scl_oe_ff <= m_scl_ff;
			sda_oe_ff <= m_sda_ff | sl_drv_ff;
		end
	end

	assign scl_oe_out    = scl_oe_ff;
	assign sda_oe_out    = sda_oe_ff;
	assign scl_level_out = 1'b0;
	assign sda_level_out = 1'b0;
	assign rd_data_out   = rd_data_ff;
	assign irq_out       = irq_ff;

	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	sequence stop_pending_s;
		fl_stop_ff && ie_ff[`TWT_ST_STOP];
	endsequence

	stop_irq_a: assert property (stop_pending_s |=> irq_out)
		else $error("stop flag enabled without interrupt");
	per_lock_a: assert property (bus_in.wr && bus_in.addr == `TWT_OFS_SCL_PER && active_ff
		|=> $stable(per_ff))
		else $error("period register changed while active");
	low_len_a: assert property (mst_ff == twt_pkg::TWT_M_LOW |-> ph_cnt_ff <= low_eff
		&& low_eff >= 8'h04)
		else $error("low phase overran");
	high_len_a: assert property (mst_ff == twt_pkg::TWT_M_HIGH |-> ph_cnt_ff <= high_eff
		&& high_eff >= 8'h02)
		else $error("high phase overran");
	slave_quiet_a: assert property (!msel ##1 !msel |-> mst_ff == twt_pkg::TWT_M_IDLE)
		else $error("clock generated in slave mode");
	tmo_clear_a: assert property (scl_fall |=> tmo_cnt_ff == 19'h00000)
		else $error("timeout count not cleared");
	tmo_off_a: assert property (tmo_ff == 8'h00 && !start_fail |=> !$rose(fl_tmo_ff))
		else $error("timeout while disabled");
	tmo_flag_a: assert property (tmo_hit |=> fl_tmo_ff ##1 mst_ff == twt_pkg::TWT_M_IDLE)
		else $error("timeout not flagged");
	match_a: assert property (addr_hit |=> fl_match_ff && !msel)
		else $error("match flag or master select wrong");
	stop_flag_a: assert property (stop_det |=> fl_stop_ff)
		else $error("stop not flagged");
	rsvd_zero_a: assert property (ie_ff[15:12] == 4'h0 && own_ff[15:10] == 6'h00)
		else $error("reserved bits set");

endmodule // twt_ctrl

// ---- test/twt_peer.sv ----
/*
 * Outside bus party: a second master that sends START, one address byte
 * and STOP, plus a clock stretcher that the bench switches.
 * Assumes the bench resolves both wires with pull-ups.
 */
`timescale 1ns/100ps
module twt_peer (
	// Resolved data wire
	input  wire logic sda_in,
	// Stretch request from the bench
	input  wire logic hold_in,
	// Pull enables, high pulls the wire low
	output logic      scl_oe_out,
	output logic      sda_oe_out
);
	localparam int HALF = 160; // Half of the 320 ns link period
	logic drv_scl;             // Own SCL pull while framing
	logic ack_seen;            // SDA low sampled in SCL high

	// Link clock stands still outside frames
	assign scl_oe_out = drv_scl | hold_in;

	initial begin
		drv_scl = 1'b0;
		sda_oe_out = 1'b0;
		ack_seen = 1'b0;
	end

	// One bit: SCL low, SDA set mid low, SCL high, sample mid high
	task automatic pulse(input logic sda_pull);
		drv_scl = 1'b1;
		#(HALF / 2) sda_oe_out = sda_pull;
		#(HALF / 2) drv_scl = 1'b0;
		#(HALF / 2) ack_seen = !sda_in;
		#(HALF / 2);
	endtask

	// START, address MSB first, ninth bit released, then STOP
	task automatic send_addr(input logic [7:0] b, output logic ack);
		int i;
		sda_oe_out = 1'b1;
		#HALF;
		for (i = 7; i >= 0; i--) begin
			pulse(!b[i]);
		end
		pulse(1'b0);
		ack = ack_seen;
		pulse(1'b1);
		sda_oe_out = 1'b0;
		#HALF;
	endtask
endmodule // twt_peer

// ---- test/twt_ctrl_tb.sv ----
/*
 * Self-checking bench of the two-wire controller: registers, SCL periods,
 * timeout, STOP and own-address interrupts.
 * Assumes twt_peer as the outside party and pull-ups on both wires.
 */
`timescale 1ns/100ps
module twt_ctrl_tb;
	// Design side
	logic              clk_in;
	logic              srst_in;
	twt_pkg::twt_bus_s bus;
	logic [15:0]       rd_data;
	logic              irq, scl_oe, sda_oe, p_scl_oe, p_sda_oe, hold;
	logic              scl_lv, sda_lv; // Open-drain drive levels
	wire               scl_w = !(scl_oe | p_scl_oe); // Pulled-up SCL
	wire               sda_w = !(sda_oe | p_sda_oe); // Pulled-up SDA
	// Bookkeeping
	int                fail_count = 0;
	int                checks = 0;
	int                cyc = 0;
	logic [31:0]       exp_q[$];      // Mask and expected read data
	logic              rd_d = 1'b0;   // Read taken at last edge
	logic [31:0]       rng = 32'd22358;
	logic              scl_seen;      // Own SCL pull seen
	logic              ack;
	int                n, i, le, he, lim;
	// Outside address, control, enables, ack, irq, status
	logic [57:0]       tab [4] = '{{8'h54, 16'h0003, 16'h0020, 2'b11, 16'h0820},
		{8'h55, 16'h0009, 16'h0020, 2'b01, 16'h0820},
		{8'h56, 16'h0001, 16'h0800, 2'b01, 16'h0800},
		{8'h56, 16'h0001, 16'h0000, 2'b00, 16'h0800}};

	twt_ctrl dut (.clk_in(clk_in), .srst_in(srst_in), .bus_in(bus), .rd_data_out(rd_data),
		.irq_out(irq), .scl_in(scl_w), .scl_level_out(scl_lv), .scl_oe_out(scl_oe),
		.sda_in(sda_w), .sda_level_out(sda_lv), .sda_oe_out(sda_oe));
	twt_peer peer (.sda_in(sda_w), .hold_in(hold), .scl_oe_out(p_scl_oe),
		.sda_oe_out(p_sda_oe));

	initial clk_in = 1'b0;
	always #20 clk_in = ~clk_in;

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// Compare read data with the oldest note, count cycles, cut hangs
	always @(posedge clk_in) begin : mon
		logic [31:0] e;
		if (rd_d) begin
			e = exp_q.pop_front();
			check(rd_data & e[31:16], e[15:0]);
		end
		rd_d <= bus.rd;
		if (scl_oe === 1'b1) scl_seen <= 1'b1;
		cyc++;
		if (cyc == 80000) begin
			fail_count++;
			conclude();
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	// One strobe edge, then one quiet edge
	task automatic acc(input logic [7:0] a, input logic [15:0] d, input logic w);
		bus <= '{addr: a, wdata: d, wr: w, rd: !w};
		@(posedge clk_in);
		bus.wr <= 1'b0;
		bus.rd <= 1'b0;
		@(posedge clk_in);
	endtask

	// Read with a noted expectation; rd_data holds the answer on return
	task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
		exp_q.push_back({m, e & m});
		acc(a, 16'h0000, 1'b0);
	endtask

	// Poll status until the controller is idle
	task automatic idle_wait();
		int k;
		for (k = 0; k < 3000; k++) begin
			rd(8'h01, 16'h0000, 16'h0000);
			if (rd_data[14] === 1'b0) break;
		end
		// A controller that never goes idle ends the run
		if (k == 3000) begin
			fail_count++;
			conclude();
		end
	endtask

	task automatic wait_oe(input logic lvl);
		int k;
		for (k = 0; k < 600 && scl_oe !== lvl; k++) @(posedge clk_in);
		// A pin that never moves ends the run
		if (k == 600) begin
			fail_count++;
			conclude();
		end
	endtask

	// Count edges while own SCL pull keeps one level
	task automatic run(input logic lvl, output int c);
		c = 0;
		while (scl_oe === lvl && c < 2000) begin
			@(posedge clk_in);
			c++;
		end
	endtask

	// Master frame; the outside party may stretch the first low phase
	task automatic frame(input logic [7:0] lo, input logic [7:0] hi, input int s);
		le = (lo < 8'h04) ? 4 : lo;
		he = (hi < 8'h02) ? 2 : hi;
		acc(8'h08, {hi, lo}, 1'b1);
		rng = xs(rng);
		acc(8'h00, {rng[7:0], 8'h07}, 1'b1);
		wait_oe(1'b1);
		hold <= (s > 0);
		run(1'b1, n);
		check(16'(n), 16'(le + 1));
		check({14'h0, scl_lv, sda_lv}, 16'h0000);
		repeat (s) @(posedge clk_in);
		hold <= 1'b0;
		run(1'b0, n);
		// High count plus one, sync and pin delay add six; a stretch adds its release edge
		check(16'(n), 16'(he + ((s > 0) ? 8 : 7)));
		rd(8'h01, 16'hc000, 16'hc000);
		acc(8'h08, 16'h0909, 1'b1);
		idle_wait();
		rd(8'h08, 16'hffff, {hi, lo});
	endtask

	initial begin
		bus = '0;
		srst_in = 1'b1;
		hold = 1'b0;
		scl_seen = 1'b0;
		repeat (5) @(posedge clk_in);
		srst_in <= 1'b0;
		@(posedge clk_in);
		// Reset values, reserved bits, unmapped place
		rd(8'h08, 16'hffff, 16'h0204);
		rd(8'h0a, 16'hffff, 16'h0000);
		rd(8'h20, 16'hffff, 16'h0000);
		acc(8'h03, 16'hffff, 1'b1);
		rd(8'h03, 16'hffff, 16'h0830);
		acc(8'h0a, 16'hffff, 1'b1);
		rd(8'h0a, 16'hffff, 16'h03ff);
		rng = xs(rng);
		acc(8'h09, {8'h00, rng[7:0]}, 1'b1);
		rd(8'h09, 16'hffff, {8'h00, rng[7:0]});
		acc(8'h09, 16'h0000, 1'b1);
		acc(8'h03, 16'h0000, 1'b1);
		// SCL periods, minimum counts, stretching, write lock
		frame(8'h00, 8'h00, 0);
		frame(8'h04, 8'h02, 12);
		frame(8'h09, 8'h05, 3);
		rng = xs(rng);
		frame(rng[7:0], rng[15:8], 7);
		// Timeout scales with the limit value
		acc(8'h08, 16'h0204, 1'b1);
		acc(8'h03, 16'h0010, 1'b1);
		for (i = 1; i <= 3; i += 2) begin
			lim = (i + 1) * 8;
			acc(8'h09, 16'(i), 1'b1);
			acc(8'h00, 16'h5507, 1'b1);
			wait_oe(1'b1);
			hold <= 1'b1;
			for (n = 0; n < 200 && irq !== 1'b1; n++) @(posedge clk_in);
			check(16'(n >= lim && n <= lim + 8), 16'h0001);
			@(posedge clk_in);
			check({14'h0, scl_oe, sda_oe}, 16'h0000);
			rd(8'h01, 16'h0010, 16'h0010);
			rd(8'h01, 16'h0010, 16'h0000);
			check({15'h0, irq}, 16'h0000);
			hold <= 1'b0;
			// A cut frame leaves no STOP behind; disabling frees the bus
			acc(8'h00, 16'h0000, 1'b1);
			idle_wait();
		end
		// Zero limit waits as long as SCL is held
		acc(8'h09, 16'h0000, 1'b1);
		acc(8'h00, 16'h5507, 1'b1);
		wait_oe(1'b1);
		hold <= 1'b1;
		repeat (400) @(posedge clk_in);
		check({15'h0, irq}, 16'h0000);
		rd(8'h01, 16'h0010, 16'h0000);
		hold <= 1'b0;
		idle_wait();
		// START refused while SCL is held low
		hold <= 1'b1;
		repeat (4) @(posedge clk_in);
		acc(8'h00, 16'h5507, 1'b1);
		repeat (8) @(posedge clk_in);
		rd(8'h01, 16'h0010, 16'h0010);
		hold <= 1'b0;
		idle_wait();
		// Target mode: no clock made, no timeout
		acc(8'h09, 16'h0001, 1'b1);
		acc(8'h00, 16'h0001, 1'b1);
		scl_seen = 1'b0;
		hold <= 1'b1;
		repeat (100) @(posedge clk_in);
		hold <= 1'b0;
		#7 peer.send_addr(8'h10, ack);
		@(posedge clk_in);
		check({15'h0, scl_seen}, 16'h0000);
		rd(8'h01, 16'h0010, 16'h0000);
		// Own address match, ack value, STOP interrupt and its enable
		acc(8'h0a, 16'h002a, 1'b1);
		for (i = 0; i < 4; i++) begin
			acc(8'h03, tab[i][33:18], 1'b1);
			acc(8'h00, tab[i][49:34], 1'b1);
			#7 peer.send_addr(tab[i][57:50], ack);
			repeat (8) @(posedge clk_in);
			check({15'h0, ack}, {15'h0, tab[i][17]});
			check({15'h0, irq}, {15'h0, tab[i][16]});
			rd(8'h01, 16'h0830, tab[i][15:0]);
			rd(8'h00, 16'h0002, 16'h0000);
		end
		conclude();
	end
endmodule // twt_ctrl_tb
